/* design/acc_pkg.sv */
package acc_pkg;
	// Register offsets of the sensor
	localparam logic [7:0] X_LOW_OFF = 8'h02;
	localparam logic [7:0] X_HIGH_OFF = 8'h03;
	localparam logic [7:0] Y_LOW_OFF = 8'h04;
	localparam logic [7:0] Y_HIGH_OFF = 8'h05;
	localparam logic [7:0] Z_LOW_OFF = 8'h06;
	localparam logic [7:0] Z_HIGH_OFF = 8'h07;
	localparam logic [7:0] RANGE_OFF = 8'h0F;
	localparam logic [7:0] PWR_OFF = 8'h11;
	localparam logic [7:0] CFG_OFF = 8'h13;
	localparam logic [7:0] SRST_OFF = 8'h14;
	// Field positions
	localparam int DEEP_BIT = 7;
	localparam int DUTY_BIT = 6;
	localparam int TIMING_BIT = 5;
	localparam int CODE_LSB = 1;
	localparam int LOCK_OFF_BIT = 6;
	localparam int FRESH_BIT = 0;
	localparam int NIB_LSB = 4;
	// Reset values and keys
	localparam logic [7:0] PWR_RST = 8'h00;
	localparam logic [7:0] CFG_RST = 8'h00;
	localparam logic [3:0] RANGE_RST = 4'h3;
	localparam logic [7:0] SRST_KEY = 8'hA5;
	// Range codes
	localparam logic [3:0] RANGE_2G = 4'h3;
	localparam logic [3:0] RANGE_4G = 4'h5;
	localparam logic [3:0] RANGE_8G = 4'h8;
	typedef enum logic [1:0] {
		ACC_R2G = 2'h0,
		ACC_R4G = 2'h1,
		ACC_R8G = 2'h2
	} acc_range_t;
	typedef enum logic [1:0] {
		ACC_NORMAL = 2'h0,
		ACC_LP_WAKE = 2'h1,
		ACC_LP_SLEEP = 2'h3,
		ACC_DEEP = 2'h2
	} acc_pstate_t;
	// Timing at 200 MHz
	localparam int CLK_NS = 5;
	localparam int SLEEP_UNIT_NS = 500000;
	localparam int TICK_CYC_DEF = SLEEP_UNIT_NS / CLK_NS;
	localparam int SETTLE_NS = 1000;
	localparam int SETTLE_CYC = (SETTLE_NS + CLK_NS - 1) / CLK_NS;
	// Sleep length in 0.5 ms units
	function automatic logic [11:0] acc_sleep_units(input logic [3:0] code);
		case (code)
			4'h6: acc_sleep_units = 12'h002;
			4'h7: acc_sleep_units = 12'h004;
			4'h8: acc_sleep_units = 12'h008;
			4'h9: acc_sleep_units = 12'h00C;
			4'hA: acc_sleep_units = 12'h014;
			4'hB: acc_sleep_units = 12'h032;
			4'hC: acc_sleep_units = 12'h064;
			4'hD: acc_sleep_units = 12'h0C8;
			4'hE: acc_sleep_units = 12'h3E8;
			4'hF: acc_sleep_units = 12'h7D0;
			default: acc_sleep_units = 12'h001;
		endcase
	endfunction
	function automatic logic [7:0] acc_low_off(input int i);
		acc_low_off = X_LOW_OFF + 8'(2 * i);
	endfunction
	// Host-side APB map
	localparam logic [11:0] HOST_CMD_OFF = 12'h000;
	localparam logic [11:0] HOST_STAT_OFF = 12'h004;
	localparam int CMD_WE_BIT = 16;
	localparam int CMD_GO_BIT = 31;
endpackage

/* design/acc_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface acc_if;
	logic req;
	logic we;
	logic [7:0] addr;
	logic [7:0] wdata;
	logic ack;
	logic [7:0] rdata;
	modport dev(input req, input we, input addr, input wdata, output ack, output rdata);
	modport host(output req, output we, output addr, output wdata, input ack, input rdata);
endinterface
`default_nettype wire

/* design/acc_dev.sv */
// The APB slave port was decided locally.
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - Power-on in normal; leave only on request
// - Normal mode samples continuously, never sleeps
// - Deep sleep: clocks off, few writes accepted
// - Deep request bit set enters deep sleep
// - Deep sleep freezes sample registers
// - Low power alternates wake and sleep
// - Duty-cycle bit set enters low power
// - Timing bit: 0 event, 1 fixed interval
// - Event wake lasts required sample count
// - Pending interrupt keeps device awake
// - Sleep after samples and link idle
// - Fixed interval pushes next sample after sleep
// - Host prefers fixed timing with FIFO
// - Host picks bandwidth matching sleep length
// - Four-bit code selects sleep length
// - Samples are 12-bit two's complement
// - High parts odd, low parts even offsets
// - Fresh flag set on update, read clears
// - Shadow lock refreshes high on low read
// - Lock-off bit makes both parts update
// - Four-bit range field selects range
// - Codes 3,5,8 give 2g,4g,8g
module acc_dev #(
	parameter int TICK_CYC = acc_pkg::TICK_CYC_DEF
) (
	input wire logic mclk_i,
	input wire logic resetn_i,
	acc_if.dev link,
	input wire logic smp_valid_i,
	input wire logic [2:0][11:0] smp_i,
	input wire logic [3:0] samples_needed_i,
	input wire logic int_hold_i,
	output logic analog_on_o,
	output logic osc_on_o,
	output logic fifo_push_o,
	output logic [2:0][11:0] fifo_data_o,
	output acc_pkg::acc_range_t range_o,
	output acc_pkg::acc_pstate_t pstate_o
);
	import acc_pkg::*;

	acc_pstate_t state;
	logic [7:0] pwr;
	logic [7:0] cfg;
	logic [3:0] range_code;
	logic ack;
	logic [7:0] rdata;
	logic take;
	logic wr;
	logic rd;
	logic soft_rst;
	logic rst;
	logic deep_req;
	logic duty_req;
	logic lock_off;
	logic acquire;
	logic got_smp;
	logic [31:0] tick_cnt;
	logic tick;
	logic [11:0] sleep_cnt;
	logic sleep_done;
	logic [7:0] settle_cnt;
	logic settled;
	logic [3:0] smp_cnt;
	logic [3:0] need;
	logic wake_done;
	logic push_pend;
	logic [2:0][3:0] low_nib;
	logic [2:0][7:0] high;
	logic [2:0][7:0] pend;
	logic [2:0] fresh;

	assign take = link.req && !ack;
	assign wr = take && link.we;
	assign rd = take && !link.we;
	assign soft_rst = wr && link.addr == SRST_OFF && link.wdata == SRST_KEY;
	assign rst = !resetn_i || soft_rst;
	assign deep_req = pwr[DEEP_BIT];
	assign duty_req = pwr[DUTY_BIT];
	assign lock_off = cfg[LOCK_OFF_BIT];
	assign link.ack = ack;
	assign link.rdata = rdata;
	assign pstate_o = state;

	// One-cycle answer; the next request is taken only after ack drops
	always_ff @(posedge mclk_i) begin
		if (!resetn_i) begin
			ack <= 1'b0;
		end else begin
			ack <= take;
		end
	end

	always_ff @(posedge mclk_i) begin
		if (rst) begin
			pwr <= PWR_RST;
			cfg <= CFG_RST;
			range_code <= RANGE_RST;
		end else if (wr) begin
			if (state == ACC_DEEP) begin
				// Asleep, only the deep request bit may change
				if (link.addr == PWR_OFF) begin
					pwr[DEEP_BIT] <= link.wdata[DEEP_BIT];
				end
			end else begin
				case (link.addr)
					PWR_OFF: pwr <= link.wdata;
					CFG_OFF: cfg <= link.wdata;
					RANGE_OFF: range_code <= link.wdata[3:0];
					default: ;
				endcase
			end
		end
	end

	always_ff @(posedge mclk_i) begin
		if (rst) begin
			state <= ACC_NORMAL;
		end else begin
			case (state)
				ACC_NORMAL: begin
					if (deep_req) begin
						state <= ACC_DEEP;
					end else if (duty_req) begin
						state <= ACC_LP_WAKE;
					end
				end
				ACC_LP_WAKE: begin
					if (deep_req) begin
						state <= ACC_DEEP;
					end else if (!duty_req) begin
						state <= ACC_NORMAL;
					end else if (wake_done) begin
						state <= ACC_LP_SLEEP;
					end
				end
				ACC_LP_SLEEP: begin
					if (deep_req) begin
						state <= ACC_DEEP;
					end else if (!duty_req) begin
						state <= ACC_NORMAL;
					end else if (sleep_done) begin
						state <= ACC_LP_WAKE;
					end
				end
				ACC_DEEP: begin
					if (!deep_req) begin
						state <= ACC_NORMAL;
					end
				end
				default: state <= ACC_NORMAL;
			endcase
		end
	end

	assign analog_on_o = state == ACC_NORMAL || state == ACC_LP_WAKE;
	assign osc_on_o = state != ACC_DEEP;

	// Sleep timer runs only while asleep on the oscillator
	assign tick = tick_cnt == 32'(TICK_CYC - 1);
	assign sleep_done = tick && sleep_cnt == acc_sleep_units(pwr[CODE_LSB +: 4]) - 12'h001;
	always_ff @(posedge mclk_i) begin
		if (rst || state != ACC_LP_SLEEP) begin
			tick_cnt <= '0;
			sleep_cnt <= '0;
		end else if (tick) begin
			tick_cnt <= '0;
			sleep_cnt <= sleep_cnt + 12'h001;
		end else begin
			tick_cnt <= tick_cnt + 32'h1;
		end
	end

	// Front end must settle after each entry into the low-power wake phase before samples count; normal mode samples at once
	assign settled = settle_cnt == 8'(SETTLE_CYC);
	assign acquire = state == ACC_NORMAL || (state == ACC_LP_WAKE && settled);
	assign got_smp = acquire && smp_valid_i;
	assign need = samples_needed_i == 4'h0 ? 4'h1 : samples_needed_i;
	assign wake_done = settled && smp_cnt >= need && !int_hold_i && !link.req;
	always_ff @(posedge mclk_i) begin
		if (rst || state != ACC_LP_WAKE) begin
			settle_cnt <= '0;
			smp_cnt <= '0;
		end else begin
			if (!settled) begin
				settle_cnt <= settle_cnt + 8'h01;
			end
			if (got_smp && smp_cnt != 4'hF) begin
				smp_cnt <= smp_cnt + 4'h1;
			end
		end
	end

	// Fixed interval: the first sample after each sleep goes to the FIFO
	always_ff @(posedge mclk_i) begin
		if (rst) begin
			push_pend <= 1'b0;
			fifo_push_o <= 1'b0;
			fifo_data_o <= '0;
		end else begin
			fifo_push_o <= 1'b0;
			if (state == ACC_LP_SLEEP && sleep_done && pwr[TIMING_BIT]) begin
				push_pend <= 1'b1;
			end else if (push_pend && got_smp) begin
				push_pend <= 1'b0;
				fifo_push_o <= 1'b1;
				fifo_data_o <= smp_i;
			end else if (state != ACC_LP_WAKE && state != ACC_LP_SLEEP) begin
				push_pend <= 1'b0;
			end
		end
	end

	// Sample registers; no capture outside acquisition keeps them frozen
	always_ff @(posedge mclk_i) begin
		if (rst) begin
			low_nib <= '0;
			high <= '0;
			pend <= '0;
		end else begin
			for (int i = 0; i < 3; i++) begin
				if (got_smp) begin
					low_nib[i] <= smp_i[i][3:0];
					pend[i] <= smp_i[i][11:4];
					if (lock_off) begin
						high[i] <= smp_i[i][11:4];
					end
				end
				if (rd && link.addr == acc_low_off(i) && !lock_off) begin
					high[i] <= pend[i];
				end
			end
		end
	end

	// A new sample in the read cycle wins over the clear
	always_ff @(posedge mclk_i) begin
		if (rst) begin
			fresh <= '0;
		end else begin
			for (int i = 0; i < 3; i++) begin
				if (got_smp) begin
					fresh[i] <= 1'b1;
				end else if (rd && (link.addr == acc_low_off(i) ||
						link.addr == acc_low_off(i) + 8'h01)) begin
					fresh[i] <= 1'b0;
				end
			end
		end
	end

	always_ff @(posedge mclk_i) begin
		if (!resetn_i) begin
			rdata <= '0;
		end else if (rd) begin
			case (link.addr)
				X_LOW_OFF: rdata <= {low_nib[0], 3'h0, fresh[0]};
				X_HIGH_OFF: rdata <= high[0];
				Y_LOW_OFF: rdata <= {low_nib[1], 3'h0, fresh[1]};
				Y_HIGH_OFF: rdata <= high[1];
				Z_LOW_OFF: rdata <= {low_nib[2], 3'h0, fresh[2]};
				Z_HIGH_OFF: rdata <= high[2];
				RANGE_OFF: rdata <= {4'h0, range_code};
				PWR_OFF: rdata <= pwr;
				CFG_OFF: rdata <= cfg;
				default: rdata <= '0;
			endcase
		end
	end

	always_comb begin
		case (range_code)
			RANGE_4G: range_o = ACC_R4G;
			RANGE_8G: range_o = ACC_R8G;
			default: range_o = ACC_R2G;
		endcase
	end
endmodule
`default_nettype wire

/* design/acc_host.sv */
`timescale 1ns/1ps
`default_nettype none
module acc_host (
	input wire logic mclk_i,
	input wire logic resetn_i,
	acc_if.host link,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr
);
	import acc_pkg::*;

	logic req;
	logic we;
	logic [7:0] addr;
	logic [7:0] wdata;
	logic [7:0] rdata;
	logic apb_wr;
	logic mapped;

	assign mapped = paddr == HOST_CMD_OFF || paddr == HOST_STAT_OFF;
	assign apb_wr = psel && penable && pwrite && paddr == HOST_CMD_OFF;
	assign pready = 1'b1;
	assign pslverr = psel && penable && !mapped;
	assign link.req = req;
	assign link.we = we;
	assign link.addr = addr;
	assign link.wdata = wdata;

	// Request held until the device answers; a command while busy is dropped
	always_ff @(posedge mclk_i) begin
		if (!resetn_i) begin
			req <= 1'b0;
			we <= 1'b0;
			addr <= '0;
			wdata <= '0;
		end else if (req) begin
			if (link.ack) begin
				req <= 1'b0;
			end
		end else if (apb_wr && pwdata[CMD_GO_BIT]) begin
			req <= 1'b1;
			addr <= pwdata[7:0];
			wdata <= pwdata[15:8];
			we <= pwdata[CMD_WE_BIT];
		end
	end

	always_ff @(posedge mclk_i) begin
		if (!resetn_i) begin
			rdata <= '0;
		end else if (req && link.ack && !we) begin
			rdata <= link.rdata;
		end
	end

	always_comb begin
		prdata = '0;
		if (paddr == HOST_CMD_OFF) begin
			prdata = {15'h0, we, wdata, addr};
		end else if (paddr == HOST_STAT_OFF) begin
			prdata = {16'h0, rdata, 7'h0, req};
		end
	end
endmodule
`default_nettype wire

/* testbench/acc_chk.sv */
`timescale 1ns/1ps
`default_nettype none
module acc_chk (
	input wire logic mclk_i,
	input wire logic resetn_i,
	input wire logic req,
	input wire logic we,
	input wire logic [7:0] addr,
	input wire logic [7:0] wdata,
	input wire logic ack,
	input wire logic [7:0] rdata
);
	import acc_pkg::*;
	default clocking cb @(posedge mclk_i);
	endclocking
	default disable iff (!resetn_i);
	a_ack_next_cycle: assert property (req && !ack |=> ack)
		else $error("ack late");
	a_ack_one_pulse: assert property (ack |=> !ack)
		else $error("ack too long");
	a_ack_has_cause: assert property (ack |-> $past(req && !ack))
		else $error("ack without request");
	a_idle_no_ack: assert property (!req |=> !ack)
		else $error("ack while idle");
	a_req_held_still: assert property (req && !ack |=> req && $stable({we, addr, wdata}))
		else $error("request changed early");
	a_req_drop_ack: assert property (ack |=> !req)
		else $error("request kept after ack");
	a_rdata_read_only: assert property (!$stable(rdata) |-> ack && !we)
		else $error("read data moved outside a read");
	a_reset_reg_zero: assert property (ack && !we && addr == SRST_OFF |-> rdata == 8'h00)
		else $error("soft reset register read not zero");
endmodule
`default_nettype wire

/* testbench/tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb;
	import acc_pkg::*;
	logic mclk_i = 1'h0;
	logic resetn_i = 1'h0;
	logic psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata;
	logic pready, pslverr, err, smp_valid = 1'h0, analog, osc, push, int_hold = 1'h0;
	logic [2:0][11:0] smp = '0, fdata, last_fifo;
	acc_range_t range;
	acc_pstate_t pstate;
	logic [7:0] q;
	int bad_count = 0, compares = 0, cycles = 0, pushes = 0, naps = 0, i;
	acc_if link_if ();
	acc_dev #(.TICK_CYC(4)) acc_dev_inst (.mclk_i(mclk_i), .resetn_i(resetn_i),
		.link(link_if.dev), .smp_valid_i(smp_valid), .smp_i(smp), .samples_needed_i(4'h1),
		.int_hold_i(int_hold), .analog_on_o(analog), .osc_on_o(osc), .fifo_push_o(push),
		.fifo_data_o(fdata), .range_o(range), .pstate_o(pstate));
	acc_host acc_host_inst (.mclk_i(mclk_i), .resetn_i(resetn_i), .link(link_if.host),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr));
	acc_chk acc_chk_inst (.mclk_i(mclk_i), .resetn_i(resetn_i), .req(link_if.req),
		.we(link_if.we), .addr(link_if.addr), .wdata(link_if.wdata), .ack(link_if.ack),
		.rdata(link_if.rdata));
	always #2.5 mclk_i = ~mclk_i;
	always @(posedge mclk_i) begin
		cycles <= cycles + 1;
		if (pstate === ACC_LP_SLEEP) begin
			naps <= naps + 1;
		end
		if (push === 1'h1) begin
			pushes <= pushes + 1;
			last_fifo <= fdata;
		end
		if (cycles == 30000) begin
			bad_count++;
			complete_run();
		end
	end
	task automatic chk(input string nm, input logic [35:0] exp, input logic [35:0] got);
		compares++;
		if (got !== exp) begin
			bad_count++;
			$display("ERROR %s expected %h seen %h", nm, exp, got);
		end
	endtask
	// Request stands until the edge that sees pready high; data is taken at that same edge
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] r);
		@(posedge mclk_i);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk_i);
		penable <= 1'h1;
		@(posedge mclk_i);
		while (pready !== 1'h1)
			@(posedge mclk_i);
		r = prdata;
		err = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask
	// Busy polling has no limit of its own; only the bench timeout ends a hang
	task automatic dev(input logic w, input logic [7:0] a, input logic [7:0] d);
		logic [31:0] r;
		apb(1'h1, HOST_CMD_OFF, {1'h1, 14'h0, w, d, a}, r);
		r = 32'h1;
		while (r[0] !== 1'h0)
			apb(1'h0, HOST_STAT_OFF, 32'h0, r);
		q = r[15:8];
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		dev(1'h0, a, 8'h00);
		chk("device register", {28'h0, exp}, {28'h0, q});
	endtask
	task automatic pulse(input logic [11:0] x);
		@(posedge mclk_i);
		smp[0] <= x;
		smp_valid <= 1'h1;
		@(posedge mclk_i);
		smp_valid <= 1'h0;
	endtask
	task automatic complete_run();
		if (bad_count == 0 && compares > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	initial begin
		logic [31:0] r;
		repeat (16) @(posedge mclk_i);
		resetn_i <= 1'h1;
		chk("state", ACC_NORMAL, pstate);
		rd(RANGE_OFF, 8'h03);
		rd(PWR_OFF, 8'h00);
		rd(CFG_OFF, 8'h00);
		apb(1'h0, 12'h008, 32'h0, r);
		chk("slave error", 1'h1, err);
		for (i = 0; i < 3; i++) begin
			dev(1'h1, RANGE_OFF, {4'h0, i == 0 ? RANGE_4G : i == 1 ? RANGE_8G : RANGE_2G});
			chk("range", i == 0 ? ACC_R4G : i == 1 ? ACC_R8G : ACC_R2G, range);
		end
		smp[1] <= 12'h7FF;
		pulse(12'hABC);
		rd(X_LOW_OFF, 8'hC1);
		rd(X_HIGH_OFF, 8'hAB);
		rd(X_LOW_OFF, 8'hC0);
		rd(Y_HIGH_OFF, 8'h00);
		rd(Y_LOW_OFF, 8'hF0);
		rd(Y_HIGH_OFF, 8'h7F);
		pulse(12'h123);
		rd(X_HIGH_OFF, 8'hAB);
		rd(X_LOW_OFF, 8'h30);
		rd(X_HIGH_OFF, 8'h12);
		dev(1'h1, CFG_OFF, 8'h40);
		pulse(12'h456);
		rd(X_HIGH_OFF, 8'h45);
		dev(1'h1, PWR_OFF, 8'h80);
		chk("deep", 4'h8, {ACC_DEEP, analog, osc});
		pulse(12'h789);
		rd(X_LOW_OFF, 8'h60);
		dev(1'h1, RANGE_OFF, 8'h08);
		rd(RANGE_OFF, 8'h03);
		dev(1'h1, PWR_OFF, 8'h00);
		chk("wake", 4'h3, {ACC_NORMAL, analog, osc});
		dev(1'h1, PWR_OFF, 8'h40);
		chk("duty", ACC_LP_WAKE, pstate);
		// A held interrupt must keep the wake phase going past settling and samples
		int_hold <= 1'h1;
		repeat (120) pulse(12'h321);
		chk("held awake", ACC_LP_WAKE, pstate);
		chk("naps while held", 32'h0, naps);
		int_hold <= 1'h0;
		for (i = 0; i < 300 && pstate !== ACC_LP_SLEEP; i++)
			pulse(12'h321);
		chk("nap", 4'hD, {ACC_LP_SLEEP, analog, osc});
		dev(1'h1, PWR_OFF, 8'h60);
		for (i = 0; i < 300 && pushes == 0; i++)
			pulse(12'h654);
		chk("fifo", {smp[2:1], 12'h654}, last_fifo);
		rd(SRST_OFF, 8'h00);
		dev(1'h1, SRST_OFF, SRST_KEY);
		chk("soft reset", ACC_NORMAL, pstate);
		rd(PWR_OFF, 8'h00);
		complete_run();
	end
endmodule
`default_nettype wire
